// >>> dsg_pkg.sv
// Package of constants, types and helpers for the deep-sleep clock gating block
package dsg_pkg;

	// Register byte offsets
	localparam logic [11:0] DSG_OFF_DEEP_GATE   = 12'h128;
	localparam logic [11:0] DSG_OFF_FAULT_STAT  = 12'h200;
	localparam logic [11:0] DSG_OFF_FAULT_MASK  = 12'h204;
	localparam logic [11:0] DSG_OFF_EFF_GATE    = 12'h208;

	// Field positions of the gating layout
	localparam int DSG_BIT_PHY    = 30;
	localparam int DSG_BIT_MAC    = 28;
	localparam int DSG_BIT_PORT_G = 6;
	localparam int DSG_BIT_PORT_A = 0;

	// Reset value and writable bits
	localparam logic [31:0] DSG_RESET_GATE = 32'h00000000;
	localparam logic [31:0] DSG_GATE_MASK  = 32'h5000007F;
	localparam logic [31:0] DSG_ZERO       = 32'h00000000;

	// Number of gated peripherals
	localparam int DSG_NUM_PERIPH = 9;

	// One enable per gated peripheral
	typedef struct packed {
		logic       phy_clock_gate;
		logic       mac_clock_gate;
		logic [6:0] port_clock_gate;
	} dsg_gate_t;

	// APB request bundle
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} dsg_apb_req_t;

	// Register word to gating vector
	function automatic dsg_gate_t dsg_reg_to_gate(input logic [31:0] word);
		dsg_gate_t g;
		g.phy_clock_gate  = word[DSG_BIT_PHY];
		g.mac_clock_gate  = word[DSG_BIT_MAC];
		g.port_clock_gate = word[DSG_BIT_PORT_G:DSG_BIT_PORT_A];
		return g;
	endfunction : dsg_reg_to_gate

	// Gating vector to register word
	function automatic logic [31:0] dsg_gate_to_reg(input dsg_gate_t g);
		logic [31:0] word;
		word = DSG_ZERO;
		word[DSG_BIT_PHY] = g.phy_clock_gate;
		word[DSG_BIT_MAC] = g.mac_clock_gate;
		word[DSG_BIT_PORT_G:DSG_BIT_PORT_A] = g.port_clock_gate;
		return word;
	endfunction : dsg_gate_to_reg

endpackage : dsg_pkg

// >>> dsg_top.sv
// Deep-sleep clock gating register, clock enable selection and access fault logic
`timescale 1ns/100ps
`default_nettype none

// Function
// R01: A peripheral's clock enable is high while its gating bit is one and low while it is zero.
// R02: An access to a peripheral whose clock is gated off is answered with a bus fault.
// R03: All gating bits of the deep-sleep register are zero after reset.
// R04: The deep-sleep register steers the enables only in deep-sleep; run and sleep have their own.
// R05: Sleep and deep-sleep settings are used only when automatic clock gating is set.
// R06: Bit 30 is a read/write enable for the Ethernet PHY clock.
// R07: Bit 28 is a read/write enable for the Ethernet MAC clock.
// R08: Bits 6 to 0 are read/write enables for ports G down to A.
// R09: Bits 31, 29 and 27:7 are reserved, read as zero and ignore writes.
// R10: The register is a 32-bit read/write word at offset 0x128.
// R11: The effective enable follows deep-sleep settings in deep-sleep with auto gating, else the mode's own.
module dsg_top
	import dsg_pkg::*;
(
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Mode and other gating registers
	input  wire logic                      sleep_mode,
	input  wire logic                      deep_sleep_mode,
	input  wire logic                      auto_clock_gating,
	input  wire logic [31:0]               run_gate_reg,
	input  wire logic [31:0]               sleep_gate_reg,
	// Peripheral access strobes and faults
	input  wire logic [DSG_NUM_PERIPH-1:0] periph_access,
	output logic      [DSG_NUM_PERIPH-1:0] periph_fault,
	// Clock enables
	output dsg_gate_t                      periph_clock_en,
	// Interrupt
	output logic                           irq
);

	// Stored state
	logic [31:0]  deep_sleep_gate_reg;
	logic [31:0]  fault_status;
	logic [31:0]  fault_mask;

	// Request bundle
	dsg_apb_req_t req;
	assign req.sel    = psel;
	assign req.enable = penable;
	assign req.write  = pwrite;
	assign req.addr   = paddr;
	assign req.wdata  = pwdata;

	// Address decode
	wire logic hit_gate  = (req.addr == DSG_OFF_DEEP_GATE);
	wire logic hit_stat  = (req.addr == DSG_OFF_FAULT_STAT);
	wire logic hit_mask  = (req.addr == DSG_OFF_FAULT_MASK);
	wire logic hit_eff   = (req.addr == DSG_OFF_EFF_GATE);
	wire logic hit_any   = hit_gate | hit_stat | hit_mask | hit_eff;

	// Access phase and completion
	wire logic access    = req.sel & req.enable;
	wire logic first_acc = access & ~pready;
	wire logic done      = access & pready;
	wire logic wr_done   = done & req.write & hit_any;
	wire logic wr_gate   = wr_done & hit_gate;
	wire logic wr_stat   = wr_done & hit_stat;
	wire logic wr_mask   = wr_done & hit_mask;

	// Effective enable selection
	wire logic use_deep  = auto_clock_gating & deep_sleep_mode;
	wire logic use_sleep = auto_clock_gating & sleep_mode & ~deep_sleep_mode;
	wire logic [31:0] sel_word = use_deep  ? deep_sleep_gate_reg :          // [R04] [R05] [R11]
	                             use_sleep ? sleep_gate_reg : run_gate_reg;  // [R05] [R11]
	wire dsg_gate_t next_clock_en = dsg_reg_to_gate(sel_word);               // [R01]

	// Faults on accesses to unclocked peripherals
	wire logic [DSG_NUM_PERIPH-1:0] next_fault = periph_access & ~periph_clock_en;  // [R02]
	wire logic [31:0] fault_word = dsg_gate_to_reg(next_fault);

	// Write data limited to implemented bits
	wire logic [31:0] gate_wdata = req.wdata & DSG_GATE_MASK;               // [R06] [R07] [R08] [R09]

	// Status with set winning over clear
	wire logic [31:0] stat_clear  = wr_stat ? (req.wdata & DSG_GATE_MASK) : DSG_ZERO;
	wire logic [31:0] next_status = (fault_status & ~stat_clear) | fault_word;

	// Read mux
	wire logic [31:0] read_word =
		hit_gate ? deep_sleep_gate_reg :                                      // [R10]
		hit_stat ? fault_status :
		hit_mask ? fault_mask :
		hit_eff  ? dsg_gate_to_reg(periph_clock_en) : DSG_ZERO;

	wire logic next_irq = |(next_status & fault_mask);

	// Deep-sleep gating register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deep_sleep_gate_reg <= DSG_RESET_GATE;                              // [R03]
		end else if (wr_gate) begin
			deep_sleep_gate_reg <= gate_wdata;                                  // [R10]
		end
	end

	// Fault mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_mask <= DSG_ZERO;
		end else if (wr_mask) begin
			fault_mask <= req.wdata & DSG_GATE_MASK;
		end
	end

	// Fault status and interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_status <= DSG_ZERO;
			irq          <= 1'b0;
		end else begin
			fault_status <= next_status;
			irq          <= next_irq;
		end
	end

	// Clock enables and fault answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_clock_en <= dsg_reg_to_gate(DSG_RESET_GATE);                 // [R03]
			periph_fault    <= '0;
		end else begin
			periph_clock_en <= next_clock_en;                                   // [R01]
			periph_fault    <= next_fault;                                      // [R02]
		end
	end

	// APB answer, one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= DSG_ZERO;
		end else begin
			pready  <= first_acc;
			pslverr <= first_acc & ~hit_any;
			prdata  <= (first_acc & ~req.write) ? read_word : DSG_ZERO;
		end
	end

endmodule : dsg_top

`default_nettype wire

// >>> dsg_asserts.sv
// Assertions for the deep-sleep clock gating block
`timescale 1ns/100ps
`default_nettype none
module dsg_asserts
	import dsg_pkg::*;
(
	// Bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Modes and gating
	input wire logic        sleep_mode,
	input wire logic        deep_sleep_mode,
	input wire logic        auto_clock_gating,
	input wire logic [31:0] run_gate_reg,
	input wire logic [31:0] sleep_gate_reg,
	input wire logic [8:0]  periph_access,
	input wire logic [8:0]  periph_fault,
	input wire dsg_gate_t   periph_clock_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       acc = psel && penable && !pready;
	wire [8:0] en  = periph_clock_en;
	function automatic logic [8:0] pick(input logic [31:0] w);
		return {w[30], w[28], w[6:0]};
	endfunction : pick
	ready_wait_a: assert property (acc |=> pready)
		else $error("no ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready stuck");
	bad_addr_a: assert property (acc && !(paddr inside {12'h128, 12'h200, 12'h204, 12'h208})
		|=> pslverr) else $error("no error on bad address");
	err_pair_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	resv_zero_a: assert property (pready && paddr == 12'h128 |-> !(prdata & ~DSG_GATE_MASK))
		else $error("reserved bit set");
	gate_fault_a: assert property (1 |=> periph_fault == $past(periph_access & ~en))
		else $error("fault mismatch");
	run_sel_a: assert property (!auto_clock_gating |=> en == pick($past(run_gate_reg)))
		else $error("run enables wrong");
	sleep_sel_a: assert property (auto_clock_gating && sleep_mode && !deep_sleep_mode
		|=> en == pick($past(sleep_gate_reg))) else $error("sleep enables wrong");
	cover property (pslverr);
	cover property (periph_fault != 0);
	cover property (auto_clock_gating && deep_sleep_mode && en != 0);
endmodule : dsg_asserts
bind dsg_top dsg_asserts u_chk (.*);
`default_nettype wire

// >>> tb.sv
// Testbench for the deep-sleep clock gating block
`timescale 1ns/100ps
`default_nettype none
module tb import dsg_pkg::*;;
	logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic        sleep_mode = '0, deep_sleep_mode = '0, auto_clock_gating = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, run_gate_reg = '0, sleep_gate_reg = '0, prdata, rd;
	logic [8:0]  periph_access = '0, periph_fault;
	logic        pready, pslverr, irq, er;
	dsg_gate_t   periph_clock_en;
	int          fails = 0, cmp_count = 0;
	dsg_top u_dut (.*);
	always #20 pclk = ~pclk;
	task automatic stop_test;
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic mode(input logic a, s, d);
		@(posedge pclk);
		auto_clock_gating <= a;
		sleep_mode <= s;
		deep_sleep_mode <= d;
		repeat (2) @(negedge pclk);
	endtask : mode
	task automatic t_fields;
		apb(1'b0, 12'h128, '0);
		chk(rd, '0);
		apb(1'b1, 12'h128, 32'hFFFFFFFF);
		apb(1'b0, 12'h128, '0);
		chk(rd, 32'h5000007F);
		mode(1'b1, 1'b0, 1'b1);
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, 12'h128, i < 7 ? 32'h1 << i : (i == 7 ? 32'h10000000 : 32'h40000000));
			repeat (2) @(negedge pclk);
			chk(periph_clock_en, 32'h1 << i);
		end
	endtask : t_fields
	task automatic t_modes;
		@(posedge pclk);
		run_gate_reg <= 32'h40000001;
		sleep_gate_reg <= 32'h10000002;
		mode(1'b0, 1'b0, 1'b1);
		chk(periph_clock_en, 32'h101);
		mode(1'b1, 1'b1, 1'b0);
		chk(periph_clock_en, 32'h082);
		mode(1'b1, 1'b1, 1'b1);
		chk(periph_clock_en, 32'h100);
	endtask : t_modes
	task automatic t_fault;
		apb(1'b1, 12'h128, 32'h1);
		@(posedge pclk);
		periph_access <= 9'h003;
		@(posedge pclk);
		periph_access <= '0;
		@(negedge pclk);
		chk(periph_fault, 32'h2);
		chk(irq, '0);
		apb(1'b1, 12'h204, 32'h2);
		repeat (2) @(negedge pclk);
		chk(irq, 32'h1);
		apb(1'b0, 12'h200, '0);
		chk(rd, 32'h2);
		apb(1'b1, 12'h200, 32'h2);
		repeat (2) @(negedge pclk);
		chk(irq, '0);
		apb(1'b0, 12'h12C, '0);
		chk(er, 32'h1);
	endtask : t_fault
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_fields;
		t_modes;
		t_fault;
		stop_test;
	end
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule : tb
`default_nettype wire
